// file: verilog/dfo_defs.svh
// Register indices, field positions, reset values and timing constants of the flag output block
`ifndef DFO_DEFS_SVH
`define DFO_DEFS_SVH

`define DFO_IDX_AUDIO_CTRL 6'h0A
`define DFO_IDX_SPEED 6'h0B
`define DFO_IDX_IRQ_STATUS 6'h10
`define DFO_IDX_IRQ_MASK 6'h11
`define DFO_IDX_FLAG_WORD 6'h12

`define DFO_AUDIO_CTRL_FLAG_BIT 3
`define DFO_SPEED_DOUBLE_BIT 0
`define DFO_AUDIO_FLAG_SLOT 4

`define DFO_AUDIO_CTRL_RST 4'h0
`define DFO_SPEED_RST 4'h0
`define DFO_IRQ_MASK_RST 4'h0

`define DFO_EV_FRAME 0
`define DFO_EV_C1_FAIL 1
`define DFO_EV_C2_FAIL 2
`define DFO_EV_CONCEAL 3

`define DFO_FLAG_BITS 7
`define DFO_CLK_HZ 20000000
`define DFO_FRAME_HZ 7350
`define DFO_FRAME_CYCLES (`DFO_CLK_HZ / `DFO_FRAME_HZ)
`define DFO_CLK_NS 50
`define DFO_BIT_NS 400
`define DFO_BIT_CYCLES ((`DFO_BIT_NS + `DFO_CLK_NS - 1) / `DFO_CLK_NS)
`define DFO_SYNC_DELAY_FRAMES 4

`endif

// file: verilog/dfo_pkg.sv
// Types shared by the flag output block and its surroundings
package dfo_pkg;
   typedef struct packed {
      logic frame_strobe;
      logic time_sync;
      logic [1:0] c1_result;
      logic [1:0] c2_result;
      logic hold_seen;
      logic interp_seen;
   } dfo_frame_status_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } dfo_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dfo_apb_rsp_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } dfo_audio_word_t;
endpackage

// file: verilog/dfo_top.sv
// Decoder error flag output: serial open-drain flag pin, audio word flag slot, APB registers
//
// Contract
// - The flag pin carries a one-bit serial flag signal refreshed once every decoded frame.
// - Flag bit one is 1 when absolute time sync is present and 0 when absent.
// - Flag bits two and three carry the first-stage result: 00 none, 01 one, 10 two, 11 failed.
// - Flag bits four and five carry the second-stage result: 00 none, 01 one, 10 two, 11 failed.
// - Flag bits six and seven carry concealment: 00 none, 01 interp, 10 hold, 11 hold and interp.
// - The time sync flag is the subcode sync delayed through the FIFO to match the audio output.
// - With bit 3 of the audio output control register set, bit 4 of each audio word holds the flag.
// - Software selects double speed via the speed register, accepted at any clock frequency.
//
// The APB register port is this design's own decision.
`include "dfo_defs.svh"

module dfo_top #(
   parameter int SYNC_DELAY_FRAMES = `DFO_SYNC_DELAY_FRAMES,
   parameter int BIT_CYCLES = `DFO_BIT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire dfo_pkg::dfo_apb_req_t apb_req,
   output dfo_pkg::dfo_apb_rsp_t apb_rsp,
   input wire dfo_pkg::dfo_frame_status_t frame_status,
   input wire dfo_pkg::dfo_audio_word_t audio_in,
   output dfo_pkg::dfo_audio_word_t audio_out,
   input wire logic error_flag_output_in,
   output logic error_flag_output_out,
   output logic error_flag_output_oe,
   output logic double_speed,
   output logic irq
);
   import dfo_pkg::*;

   typedef enum logic [0:0] {DFO_IDLE, DFO_SHIFT} dfo_state_t;

   function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
      hit = (addr == {idx, 2'b00});
   endfunction

   // Open drain: the line is pulled low only for a 0 bit
   function automatic logic drive_low(input logic flag_bit);
      drive_low = ~flag_bit;
   endfunction

   // Correction stage result that could not be repaired
   function automatic logic failed(input logic [1:0] result);
      failed = &result;
   endfunction

   // Register bus state
   logic [3:0] audio_ctrl, next_audio_ctrl;
   logic [3:0] speed_select, next_speed_select;
   logic [3:0] irq_status, next_irq_status;
   logic [3:0] irq_mask, next_irq_mask;
   logic next_irq;
   dfo_apb_rsp_t next_apb_rsp;

   // Serializer state
   dfo_state_t state, next_state;
   logic [6:0] shift_word, next_shift_word;
   logic [6:0] last_word, next_last_word;
   logic [2:0] bit_idx, next_bit_idx;
   logic [15:0] bit_cnt, next_bit_cnt;
   logic flag_oe, next_flag_oe;
   logic flag_level, next_flag_level;
   logic [SYNC_DELAY_FRAMES-1:0] sync_pipe, next_sync_pipe;

   // Audio word path
   dfo_audio_word_t next_audio_out;

   logic access, wr, rd, mapped;
   logic [3:0] events;
   logic [6:0] frame_word;

   // Pin readback
   logic pin_level, next_pin_level;

   // Flag word of the frame just closed: bit 6 leaves first
   always_comb begin
      frame_word = {sync_pipe[SYNC_DELAY_FRAMES-1],
                    frame_status.c1_result,
                    frame_status.c2_result,
                    frame_status.hold_seen, frame_status.interp_seen};
   end

   // Events latched into the sticky status
   always_comb begin
      events = 4'h0;
      if (frame_status.frame_strobe) begin
         events[`DFO_EV_FRAME] = 1'b1;
         events[`DFO_EV_C1_FAIL] = failed(frame_status.c1_result);
         events[`DFO_EV_C2_FAIL] = failed(frame_status.c2_result);
         events[`DFO_EV_CONCEAL] = frame_status.hold_seen | frame_status.interp_seen;
      end
   end

   // Subcode sync delayed frame by frame to line up with the audio leaving the FIFO
   always_comb begin
      next_sync_pipe = sync_pipe;
      if (frame_status.frame_strobe) begin
         if (SYNC_DELAY_FRAMES > 1) begin
            next_sync_pipe = SYNC_DELAY_FRAMES'({sync_pipe, frame_status.time_sync});
         end else begin
            next_sync_pipe = {SYNC_DELAY_FRAMES{frame_status.time_sync}};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_pipe <= '0;
      end else begin
         sync_pipe <= next_sync_pipe;
      end
   end

   // Serializer: open drain, pulls low for a 0, released for a 1 or when idle
   always_comb begin
      next_state = state;
      next_shift_word = shift_word;
      next_last_word = last_word;
      next_bit_idx = bit_idx;
      next_bit_cnt = bit_cnt;
      next_flag_oe = 1'b0;
      next_flag_level = 1'b1;
      if (frame_status.frame_strobe) begin
         next_state = DFO_SHIFT;
         next_shift_word = frame_word;
         next_last_word = frame_word;
         next_bit_idx = 3'h0;
         next_bit_cnt = 16'h0000;
         next_flag_oe = drive_low(frame_word[6]);
         next_flag_level = frame_word[6];
      end else begin
         unique case (state)
            DFO_IDLE: begin
               next_bit_cnt = 16'h0000;
            end
            DFO_SHIFT: begin
               next_flag_oe = drive_low(shift_word[6]);
               next_flag_level = shift_word[6];
               if (bit_cnt == 16'(BIT_CYCLES - 1)) begin
                  next_bit_cnt = 16'h0000;
                  next_shift_word = {shift_word[5:0], 1'b1};
                  if (bit_idx == 3'(`DFO_FLAG_BITS - 1)) begin
                     next_state = DFO_IDLE;
                     next_flag_oe = 1'b0;
                     next_flag_level = 1'b1;
                  end else begin
                     next_bit_idx = bit_idx + 3'h1;
                     next_flag_oe = drive_low(shift_word[5]);
                     next_flag_level = shift_word[5];
                  end
               end else begin
                  next_bit_cnt = bit_cnt + 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DFO_IDLE;
         shift_word <= 7'h7F;
         last_word <= 7'h00;
         bit_idx <= 3'h0;
         bit_cnt <= 16'h0000;
         flag_oe <= 1'b0;
         flag_level <= 1'b1;
      end else begin
         state <= next_state;
         shift_word <= next_shift_word;
         last_word <= next_last_word;
         bit_idx <= next_bit_idx;
         bit_cnt <= next_bit_cnt;
         flag_oe <= next_flag_oe;
         flag_level <= next_flag_level;
      end
   end

   assign error_flag_output_out = 1'b0;
   assign error_flag_output_oe = flag_oe;

   // Audio words pass with one cycle of delay, flag level in bit 4 when enabled
   always_comb begin
      next_audio_out = audio_in;
      if (audio_ctrl[`DFO_AUDIO_CTRL_FLAG_BIT]) begin
         next_audio_out.data[`DFO_AUDIO_FLAG_SLOT] = flag_level;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audio_out <= '0;
      end else begin
         audio_out <= next_audio_out;
      end
   end

   // APB handshake decode: one wait state, response registered
   always_comb begin
      access = apb_req.psel & apb_req.penable & apb_rsp.pready;
      wr = access & apb_req.pwrite;
      rd = access & ~apb_req.pwrite;
      mapped = hit(apb_req.paddr, `DFO_IDX_AUDIO_CTRL) | hit(apb_req.paddr, `DFO_IDX_SPEED)
             | hit(apb_req.paddr, `DFO_IDX_IRQ_STATUS) | hit(apb_req.paddr, `DFO_IDX_IRQ_MASK)
             | hit(apb_req.paddr, `DFO_IDX_FLAG_WORD);
   end

   // Control registers: audio copy and speed write only, mask reads back
   always_comb begin
      next_audio_ctrl = audio_ctrl;
      next_speed_select = speed_select;
      next_irq_mask = irq_mask;
      if (wr && hit(apb_req.paddr, `DFO_IDX_AUDIO_CTRL)) begin
         next_audio_ctrl = apb_req.pwdata[3:0];
      end
      if (wr && hit(apb_req.paddr, `DFO_IDX_SPEED)) begin
         next_speed_select = apb_req.pwdata[3:0];
      end
      if (wr && hit(apb_req.paddr, `DFO_IDX_IRQ_MASK)) begin
         next_irq_mask = apb_req.pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audio_ctrl <= `DFO_AUDIO_CTRL_RST;
         speed_select <= `DFO_SPEED_RST;
         irq_mask <= `DFO_IRQ_MASK_RST;
         double_speed <= 1'b0;
      end else begin
         audio_ctrl <= next_audio_ctrl;
         speed_select <= next_speed_select;
         irq_mask <= next_irq_mask;
         double_speed <= next_speed_select[`DFO_SPEED_DOUBLE_BIT];
      end
   end

   // Sticky status: only the bits reported are cleared, a set in the same cycle wins
   always_comb begin
      next_irq_status = irq_status;
      if (rd && hit(apb_req.paddr, `DFO_IDX_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~apb_rsp.prdata[3:0];
      end
      next_irq_status = next_irq_status | events;
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= next_irq;
      end
   end

   // Level on the flag pin, reported in the flag word register
   always_comb begin
      next_pin_level = error_flag_output_in;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_level <= 1'b1;
      end else begin
         pin_level <= next_pin_level;
      end
   end

   // Read data and error response, standing one cycle with pready
   always_comb begin
      next_apb_rsp = '0;
      if (apb_req.psel && apb_req.penable && !apb_rsp.pready) begin
         next_apb_rsp.pready = 1'b1;
         next_apb_rsp.pslverr = ~mapped;
         if (!apb_req.pwrite) begin
            if (hit(apb_req.paddr, `DFO_IDX_IRQ_STATUS)) begin
               next_apb_rsp.prdata = {28'h0000000, irq_status};
            end else if (hit(apb_req.paddr, `DFO_IDX_IRQ_MASK)) begin
               next_apb_rsp.prdata = {28'h0000000, irq_mask};
            end else if (hit(apb_req.paddr, `DFO_IDX_FLAG_WORD)) begin
               next_apb_rsp.prdata = {22'h00000, pin_level, state == DFO_SHIFT,
                                      1'b0, last_word};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp <= next_apb_rsp;
      end
   end
endmodule

// file: verif/dfo_props.sv
// Checker of the flag output block ports
module dfo_props #(
   parameter int BIT_CYCLES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire dfo_pkg::dfo_apb_req_t apb_req,
   input wire dfo_pkg::dfo_apb_rsp_t apb_rsp,
   input wire dfo_pkg::dfo_frame_status_t frame_status,
   input wire dfo_pkg::dfo_audio_word_t audio_in,
   input wire dfo_pkg::dfo_audio_word_t audio_out,
   input wire logic error_flag_output_oe,
   input wire logic double_speed
);
   timeunit 1ns;
   timeprecision 1ns;
   import dfo_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [7:0] fv = frame_status;
   wire logic st = fv[7];
   wire logic oe = error_flag_output_oe;
   sequence s_wait;
      apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence
   sequence s_spd;
      apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready && apb_req.paddr == 8'h2C;
   endsequence
   a_pready_wait: assert property (s_wait |=> apb_rsp.pready)
      else $error("no answer after wait");
   a_speed_lands: assert property (s_spd |=> double_speed == $past(apb_req.pwdata[0]))
      else $error("speed not taken");
   a_bit_hold: assert property (st |-> ##2 $stable(oe) [*7])
      else $error("bit not held");
   a_c1_hi: assert property (st |-> ##9 oe == !$past(fv[5], 9))
      else $error("c1 high wrong");
   a_c1_lo: assert property (st |-> ##17 oe == !$past(fv[4], 17))
      else $error("c1 low wrong");
   a_c2_hi: assert property (st |-> ##25 oe == !$past(fv[3], 25))
      else $error("c2 high wrong");
   a_c2_lo: assert property (st |-> ##33 oe == !$past(fv[2], 33))
      else $error("c2 low wrong");
   a_hold_bit: assert property (st |-> ##41 oe == !$past(fv[1], 41))
      else $error("hold bit wrong");
   a_interp_bit: assert property (st |-> ##49 oe == !$past(fv[0], 49))
      else $error("interp bit wrong");
   a_line_released: assert property (st |-> ##57 !oe)
      else $error("line not released");
   a_audio_copy: assert property (audio_in.valid |=> audio_out.valid
      && audio_out.data[31:5] == $past(audio_in.data[31:5]))
      else $error("audio word not copied");
endmodule
bind dfo_top dfo_props #(.BIT_CYCLES(BIT_CYCLES)) i_dfo_props (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .frame_status(frame_status), .audio_in(audio_in),
   .audio_out(audio_out), .error_flag_output_oe(error_flag_output_oe),
   .double_speed(double_speed));

// file: verif/dfo_flag_rx.sv
// Far side logic sampling the serial flag line
module dfo_flag_rx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic line,
   input wire logic strobe,
   output logic [6:0] word,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = -1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= -1;
         word <= '0;
         done <= 1'b0;
      end else if (strobe) begin
         cnt <= 0;
         done <= 1'b0;
      end else if (cnt >= 0 && cnt < 56) begin
         cnt <= cnt + 1;
         if (cnt % 8 == 4) word <= {word[5:0], line};
         if (cnt == 55) done <= 1'b1;
      end
   end
endmodule

// file: verif/tb.sv
// Self-checking bench of the flag output block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dfo_pkg::*;
   logic pclk = 0, presetn = 0, oe, fo, dsp, irq, done, err;
   dfo_apb_req_t rq = '0;
   dfo_apb_rsp_t rs;
   dfo_frame_status_t fs = '0;
   dfo_audio_word_t ai = '0, ao;
   logic [6:0] word, last = 7'h00;
   logic copy = 1'b0;
   logic [31:0] seed = 32'h2DCA3BE8, rd;
   logic sq[$];
   int fail_count = 0, checked = 0, cyc = 0;
   wire pin = oe ? 1'b0 : 1'b1;
   dfo_top i_dfo_top (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs),
      .frame_status(fs), .audio_in(ai), .audio_out(ao), .error_flag_output_in(pin),
      .error_flag_output_out(fo), .error_flag_output_oe(oe), .double_speed(dsp), .irq(irq));
   dfo_flag_rx i_dfo_flag_rx (.pclk(pclk), .presetn(presetn), .line(pin),
      .strobe(fs.frame_strobe), .word(word), .done(done));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      rq <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      rq.penable <= 1'b1;
      do @(posedge pclk); while (rs.pready !== 1'b1);
      rd = rs.prdata;
      err = rs.pslverr;
      rq <= '0;
      @(posedge pclk);
   endtask
   task automatic frame(input logic [6:0] r);
      last = {sq.pop_front(), r[5:0]};
      sq.push_back(r[6]);
      fs <= {1'b1, r};
      @(posedge pclk);
      fs.frame_strobe <= 1'b0;
      for (int i = 1; i <= 60; i++) begin
         @(posedge pclk);
         if (copy && i % 8 == 5) chk(ao.data[4], last[6 - i / 8]);
      end
      if (copy) chk(ao.data[4], 1'b1);
      chk({done, fo, word}, {2'b10, last});
   endtask
   task automatic audio(input logic [31:0] e);
      ai <= '{1'b1, seed & 32'hFFFFFFEF};
      repeat (2) @(posedge pclk);
      chk(ao, {1'b1, e});
   endtask
   initial begin
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      repeat (4) sq.push_back(1'b0);
      frame(7'h7F);
      frame(7'h00);
      frame(7'h55);
      frame(7'h2A);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         frame(seed[6:0]);
      end
      apb(1'b1, 8'h2C, 32'h1);
      chk(dsp, 1'b1);
      apb(1'b0, 8'h2C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h2C, 32'h0);
      chk(dsp, 1'b0);
      apb(1'b0, 8'h00, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 8'h44, 32'h2);
      apb(1'b0, 8'h40, 32'h0);
      frame(7'h30);
      chk(irq, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h3);
      chk(irq, 1'b0);
      frame(7'h0C);
      chk(irq, 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h5);
      seed = lfsr(seed);
      audio({seed[31:5], 1'b0, seed[3:0]});
      apb(1'b1, 8'h28, 32'h8);
      copy = 1'b1;
      audio({seed[31:5], 1'b1, seed[3:0]});
      frame(7'h2D);
      apb(1'b0, 8'h48, 32'h0);
      chk(rd, {22'h00000, 3'b100, last});
      print_verdict();
   end
endmodule
